// ==== common/sbap_pkg.sv ====
// Purpose: Shared constants for the split bus address port
// Assumes: One 100 MHz clock, synchronous active-low reset
// Notes:   Widths, reset values, synchroniser depth and phase type; no logic here
package sbap_pkg;
  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // ==========================================================
  // Reset values
  localparam logic [7:0]  ADDR_RST = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // ==========================================================
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  typedef enum {
    SB_STRAP_WAIT,
    SB_RUN
  } sbap_phase_t;
endpackage : sbap_pkg

// ==== logic/sbap_sync.sv ====
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are levels from outside the clock domain
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
module sbap_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sbap_sync_t;

  sbap_sync_t st;
  sbap_sync_t next_st;

  initial begin
    if (WIDTH < 1) $error("sbap_sync: WIDTH must be positive");
  end

  always_comb begin
    next_st      = st;
    next_st.meta = async;
    next_st.sync = st.meta;
  end

  // No reset on purpose: a cleared stage would show a false strap
  // and a false write edge in the first cycles after release
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign synced = st.sync;
endmodule : sbap_sync

// ==== logic/sbap_port.sv ====
// Purpose: Address phase front end of the parallel host port
// Assumes: Pins are asynchronous and pass two flops first
// Notes:   Strap is caught once, in the first cycle after reset
//
// Operation
// (RULE1) Strap selects latch or indicator strobe use
// (RULE2) Strap caught at power-up, then held
// (RULE3) Latch mode: strobe fall captures address
// (RULE4) Indicator mode: sample indicator at write rise
// (RULE5) Indicator high means address, low means data
// (RULE6) Host ties strap high in generic mode
// (RULE7) Separate data bus is sixteen bits
// (RULE8) Shared bus carries address then data
// (RULE9) Data write targets last captured address
`timescale 1ns/1ps
module sbap_port #(
  parameter int AW = sbap_pkg::ADDR_W,
  parameter int DW = sbap_pkg::DATA_W
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          splitBusMode,
  input  wire logic          busPhaseSelectStrap,
  input  wire logic          strobeOrIndicatorPin,
  input  wire logic          wrStrobe_n,
  input  wire logic [AW-1:0] adIn,
  input  wire logic [DW-1:0] dataIn,
  output logic      [AW-1:0] regAddr,
  output logic               addrStrobe,
  output logic      [AW-1:0] regWrData,
  output logic               regWrStrobe,
  output logic      [DW-1:0] wideData,
  output logic               wideWrStrobe,
  output logic               indicatorMode
);
  import sbap_pkg::*;

  initial begin
    if (AW != ADDR_W) $error("sbap_port: AW must be 8");
    if (DW != DATA_W) $error("sbap_port: DW must be 16");
  end

  // ==========================================================
  // Pin synchronisers
  localparam int SW = AW + DW + 4;
  logic [SW-1:0] pinSync;

  sbap_sync #(
    .WIDTH (SW)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .async   ({splitBusMode, busPhaseSelectStrap, strobeOrIndicatorPin,
                wrStrobe_n, adIn, dataIn}),
    .synced  (pinSync)
  );

  logic          sMode;
  logic          sStrap;
  logic          sStrobe;
  logic          sWr_n;
  logic [AW-1:0] sAd;
  logic [DW-1:0] sData;
  assign {sMode, sStrap, sStrobe, sWr_n, sAd, sData} = pinSync;

  // ==========================================================
  // State
  typedef struct packed {
    sbap_phase_t   phase;
    logic          indMode;
    logic          prevStrobe;
    logic          prevWr_n;
    logic [AW-1:0] addr;
    logic          addrStb;
    logic [AW-1:0] wrData;
    logic          wrStb;
    logic [DW-1:0] wide;
    logic          wideStb;
  } sbap_state_t;

  sbap_state_t st;
  sbap_state_t next_st;

  always_comb begin
    next_st            = st;
    next_st.addrStb    = 1'b0;
    next_st.wrStb      = 1'b0;
    next_st.wideStb    = 1'b0;
    next_st.prevStrobe = sStrobe;
    next_st.prevWr_n   = sWr_n;
    case (st.phase)
      SB_STRAP_WAIT: begin
        // (RULE2) Strap caught once
        // (RULE1) Strap used in split mode only
        // Generic mode behaves as strap high, matching the tie-off
        next_st.indMode = sMode ? sStrap : 1'b1;
        next_st.phase   = SB_RUN;
      end
      SB_RUN: begin
        if (!st.indMode) begin
          // (RULE3) Falling strobe captures address
          if (st.prevStrobe && !sStrobe) begin
            next_st.addr    = sAd;
            next_st.addrStb = 1'b1;
          end
          // (RULE9) Write to latched address
          if (!st.prevWr_n && sWr_n) begin
            next_st.wrData = sAd;
            next_st.wrStb  = 1'b1;
          end
        end else if (!st.prevWr_n && sWr_n) begin
          // (RULE4) Indicator sampled at write rise
          // (RULE5) High address, low data
          if (sStrobe) begin
            next_st.addr    = sAd;
            next_st.addrStb = 1'b1;
          end else begin
            // (RULE8) Data phase follows address
            // (RULE9) Data goes to last address
            next_st.wrData = sAd;
            next_st.wrStb  = 1'b1;
          end
        end
        // (RULE7) Sixteen-bit data bus capture
        if (!st.prevWr_n && sWr_n) begin
          next_st.wide    = sData;
          next_st.wideStb = 1'b1;
        end
      end
      default: begin
        next_st.phase = SB_STRAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st.phase      <= SB_STRAP_WAIT;
      st.indMode    <= 1'b1;
      st.prevStrobe <= 1'b1;
      st.prevWr_n   <= 1'b1;
      st.addr       <= ADDR_RST;
      st.addrStb    <= 1'b0;
      st.wrData     <= ADDR_RST;
      st.wrStb      <= 1'b0;
      st.wide       <= DATA_RST;
      st.wideStb    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign regAddr       = st.addr;
  assign addrStrobe    = st.addrStb;
  assign regWrData     = st.wrData;
  assign regWrStrobe   = st.wrStb;
  assign wideData      = st.wide;
  assign wideWrStrobe  = st.wideStb;
  assign indicatorMode = st.indMode;
endmodule : sbap_port

// ==== bench/sbap_port_chk.sv ====
// Purpose: Timing checks on the split bus address port
// Assumes: Pulse latency of two to five cycles after a pin edge
// Notes:   Bound to every instance of the port
`timescale 1ns/1ps
module sbap_port_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       indicatorMode,
  input wire logic       strobeOrIndicatorPin,
  input wire logic       wrStrobe_n,
  input wire logic [7:0] adIn,
  input wire logic       addrStrobe,
  input wire logic [7:0] regAddr,
  input wire logic       regWrStrobe,
  input wire logic [7:0] regWrData,
  input wire logic       wideWrStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Checks
  property p_lf;
    !indicatorMode && $fell(strobeOrIndicatorPin) |-> ##[2:5] addrStrobe;
  endproperty
  a_lf: assert property (p_lf) else $error("no latch address");
  property p_ia;
    indicatorMode && $rose(wrStrobe_n) && strobeOrIndicatorPin
      |-> ##[2:5] addrStrobe;
  endproperty
  a_ia: assert property (p_ia) else $error("no address");
  property p_id;
    indicatorMode && $rose(wrStrobe_n) && !strobeOrIndicatorPin
      |-> ##[2:5] regWrStrobe;
  endproperty
  a_id: assert property (p_id) else $error("no data write");
  property p_wd;
    $rose(wrStrobe_n) |-> ##[2:5] wideWrStrobe;
  endproperty
  a_wd: assert property (p_wd) else $error("no wide write");
  property p_av;
    addrStrobe |-> regAddr == $past(adIn, 4);
  endproperty
  a_av: assert property (p_av) else $error("bad address");
  property p_dv;
    regWrStrobe |-> regWrData == $past(adIn, 4);
  endproperty
  a_dv: assert property (p_dv) else $error("bad data");
  property p_tg;
    regWrStrobe |-> $stable(regAddr);
  endproperty
  a_tg: assert property (p_tg) else $error("address moved");
  // Strap use is frozen from the second edge after release
  property p_hd;
    $past(reset_n, 2) |-> $stable(indicatorMode);
  endproperty
  a_hd: assert property (p_hd) else $error("scheme changed");
endmodule : sbap_port_chk
bind sbap_port sbap_port_chk sbap_port_chk_i (.*);

// ==== bench/sbap_host.sv ====
// Purpose: Host side of the multiplexed bus
// Assumes: Levels held w cycles (4 or 9 here) before and eight after each act
// Notes:   Released address and data lines show the inverse of the last value; strobe returns high
`timescale 1ns/1ps
module sbap_host (
  input  wire logic  clk,
  output logic       strobeOrIndicatorPin,
  output logic       wrStrobe_n,
  output logic [7:0] adIn,
  output logic [15:0] dataIn
);
  initial begin
    strobeOrIndicatorPin = 1;
    wrStrobe_n = 1;
    adIn = 8'h00;
    dataIn = 16'h0000;
  end
  task automatic cyc(input logic lat, ind, input logic [7:0] a,
                     input logic [15:0] d, input int w);
    @(posedge clk);
    adIn <= a;
    dataIn <= d;
    strobeOrIndicatorPin <= ind;
    wrStrobe_n <= lat;
    repeat (w) @(posedge clk);
    if (lat) strobeOrIndicatorPin <= 0;
    else wrStrobe_n <= 1;
    repeat (8) @(posedge clk);
    adIn <= ~a;
    dataIn <= ~d;
    strobeOrIndicatorPin <= 1;
  endtask : cyc
endmodule : sbap_host

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the split bus address port
// Assumes: Host model drives all pins but strap and mode
// Notes:   Three resets cover both schemes and generic mode
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, reset_n = 0, splitBusMode = 1, busPhaseSelectStrap = 0;
  logic strobeOrIndicatorPin, wrStrobe_n, addrStrobe, regWrStrobe;
  logic wideWrStrobe, indicatorMode;
  logic [7:0] adIn, regAddr, regWrData;
  logic [15:0] dataIn, wideData;
  int num_errors = 0, checks = 0;
  int addrCnt = 0, wrCnt = 0, wideCnt = 0;
  always @(posedge clk) begin
    if (addrStrobe === 1'b1) addrCnt++;
    if (regWrStrobe === 1'b1) wrCnt++;
    if (wideWrStrobe === 1'b1) wideCnt++;
  end
  sbap_port sbap_port_i (.*);
  sbap_host sbap_host_i (.*);
  initial forever #5 clk = ~clk;
  task chk(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rst(input logic s, m);
    @(posedge clk);
    reset_n <= 0;
    busPhaseSelectStrap <= s;
    splitBusMode <= m;
    repeat (6) @(posedge clk);
    reset_n <= 1;
    repeat (2) @(posedge clk);
    #1;
  endtask : rst
  task t_latch;
    rst(0, 1);
    chk(indicatorMode, 0);
    sbap_host_i.cyc(1, 1, 8'h5a, 16'h8001, 4);
    chk(regAddr, 8'h5a);
    sbap_host_i.cyc(0, 1, 8'ha5, 16'h7ffe, 9);
    chk(regWrData, 8'ha5);
    chk(regAddr, 8'h5a);
    chk(wideData, 16'h7ffe);
    busPhaseSelectStrap <= 1;
    sbap_host_i.cyc(1, 1, 8'h3c, 16'h0000, 4);
    chk(indicatorMode, 0);
    chk(regAddr, 8'h3c);
    chk(16'(addrCnt), 16'h0002);
    chk(16'(wrCnt), 16'h0001);
    chk(16'(wideCnt), 16'h0001);
    $display("latch test done");
  endtask : t_latch
  task t_ind;
    rst(1, 1);
    chk(indicatorMode, 1);
    sbap_host_i.cyc(0, 1, 8'hc3, 16'h1234, 4);
    chk(regAddr, 8'hc3);
    sbap_host_i.cyc(0, 0, 8'h96, 16'hffff, 9);
    chk(regWrData, 8'h96);
    chk(regAddr, 8'hc3);
    chk(16'(addrCnt), 16'h0003);
    chk(16'(wrCnt), 16'h0002);
    chk(16'(wideCnt), 16'h0003);
    $display("indicator test done");
  endtask : t_ind
  task t_gen;
    rst(1, 0);
    chk(indicatorMode, 1);
    $display("generic test done");
  endtask : t_gen
  task test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  initial begin
    t_latch;
    t_ind;
    t_gen;
    test_done;
  end
  initial begin
    repeat (500) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule : tb_top
